// ### ulbrs_pkg.sv
// constants and types for the lin break and receive status block
package ulbrs_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] STS2_IDX = 8'h1d;
    localparam logic [7:0] EVT_IDX = 8'h20;
    localparam logic [7:0] MASK_IDX = 8'h21;
    localparam logic [7:0] CTRL_IDX = 8'h22;
    localparam logic [7:0] DATA_IDX = 8'h23;
    localparam logic [7:0] STS2_ADDR = {STS2_IDX[5:0], 2'b00};
    localparam logic [7:0] EVT_ADDR = {EVT_IDX[5:0], 2'b00};
    localparam logic [7:0] MASK_ADDR = {MASK_IDX[5:0], 2'b00};
    localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] DATA_ADDR = {DATA_IDX[5:0], 2'b00};
    // serial_status_two fields
    localparam int STS2_BRK = 7;
    localparam int STS2_EDGE = 6;
    localparam int STS2_INV = 4;
    localparam int STS2_WIDLE = 3;
    localparam int STS2_LONG = 2;
    localparam int STS2_LIN_BREAK_DETECT_ENABLE = 1;
    localparam int STS2_RAF = 0;
    // event status and mask fields
    localparam int EVT_BRK = 0;
    localparam int EVT_EDGE = 1;
    localparam int EVT_IDLE = 2;
    localparam int EVT_FE = 3;
    localparam int EVT_FULL = 4;
    localparam int EVT_N = 5;
    // control fields
    localparam int CTRL_NINE = 0;
    localparam int CTRL_STBY = 1;
    localparam int CTRL_SBK = 2;
    // reset values
    localparam logic [3:0] STS2_CFG_RST = 4'h0;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // timing: clock period in ns, character and break lengths in bit times, last data bit index
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [4:0] CHAR_BITS_8 = 5'h0a;
    localparam logic [4:0] CHAR_BITS_9 = 5'h0b;
    localparam logic [4:0] BRK_TX_SHORT = 5'h0a;
    localparam logic [4:0] BRK_TX_LONG = 5'h0d;
    localparam logic [4:0] BRK_DET_STD = 5'h0a;
    localparam logic [4:0] BRK_DET_LIN_8 = 5'h0b;
    localparam logic [4:0] BRK_DET_LIN_9 = 5'h0c;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_STOP = 3'b011,
        RX_WAIT = 3'b100
    } ulbrs_rx_state_t;
endpackage : ulbrs_pkg

// ### ulbrs_sticky.sv
// sticky event flag, cleared on request, set wins over clear
`timescale 1ns/1ps
module ulbrs_sticky (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // event and clear
    input wire logic set,
    input wire logic clr,
    // flag
    output logic q
);
    logic q_r;
    logic q_nxt;

    always_comb begin
        q_nxt = set | (q_r & ~clr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : ulbrs_sticky

// ### ulbrs_top.sv
// serial receiver status, lin break detect and break transmit with axi4-lite registers
// Operation
// - with break detection enabled, a received break sets the break flag in bit 7.
// - the break flag clears only on a software write of one to its bit.
// - an active receive edge (falling, or rising when inverted) sets the edge flag in bit 6.
// - the edge flag clears only on a software write of one and otherwise stays set.
// - bit 4 inverts the receive input for every element of the frame.
// - in standby the idle flag is set by an idle character only when bit 3 is one.
// - a sent break lasts 10 or 13 bit times, one more in 9-bit mode.
// - bit 2 changes only the sent break length, never framing error detection.
// - while bit 1 is set the framing error and buffer full flags cannot set.
// - with lin detection a break needs 11 low bit times, or 12 in 9-bit mode.
// - without lin detection the break threshold is 10 bit times, with it one more, or two more in 9-bit mode.
// - bit 0 sets at the falling edge of a start bit and clears on a false start or when the line goes idle.
// - the idle flag sets after a character time of high line following activity.
// - a zero where the stop bit belongs sets framing error with buffer full.
`timescale 1ns/1ps
module ulbrs_top #(
    parameter int BIT_CLKS = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial line
    input wire logic rxd,
    output logic txd,
    // interrupt
    output logic irq
);
    localparam logic [15:0] HALF_LIM = 16'(BIT_CLKS / 2 - 1);
    localparam logic [15:0] FULL_LIM = 16'(BIT_CLKS - 1);

    ulbrs_pkg::ulbrs_rx_state_t rx_state_r, rx_state_nxt;
    logic [15:0] cyc_r, cyc_nxt, low_r, low_nxt, high_r, high_nxt, tx_cyc_r, tx_cyc_nxt;
    logic [3:0] nbit_r, nbit_nxt;
    logic [8:0] shift_r, shift_nxt, rxdata_r, rxdata_nxt;
    logic raf_r, raf_nxt, armed_r, armed_nxt, rx_prev_r;
    logic inv_r, inv_nxt, widle_r, widle_nxt, long_r, long_nxt, lin_break_detect_enable_r, lin_break_detect_enable_nxt;
    logic nine_r, nine_nxt, stby_r, stby_nxt, tx_act_r, tx_act_nxt, txd_r, txd_nxt;
    logic [4:0] mask_r, mask_nxt, evt_set, evt_clr, evt_q;
    logic irq_r, irq_nxt, fe_evt, full_evt;
    // bus state
    logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_data;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt, rd_ok;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

    // derived terms
    logic rx_c, rx_prev_c, edge_evt, aw_take, w_take, ar_take, do_write, wr_en, wr_hit;
    logic wr_sts2, wr_evt, wr_mask, wr_ctrl, brk_det, brk_evt, idle_det, idle_set;
    logic [4:0] char_bits, brk_bits, tx_bits;
    logic [15:0] char_lim, brk_lim, tx_lim;
    logic [3:0] last_bit;

    assign rx_c = rxd ^ inv_r;
    assign rx_prev_c = rx_prev_r ^ inv_r;
    assign edge_evt = rx_prev_c & ~rx_c;
    assign char_bits = nine_r ? ulbrs_pkg::CHAR_BITS_9 : ulbrs_pkg::CHAR_BITS_8;
    assign char_lim = 16'(char_bits * BIT_CLKS);
    // break threshold: 10 normally, 11/12 with lin detection; long_r has no say here
    assign brk_bits = lin_break_detect_enable_r ? (nine_r ? ulbrs_pkg::BRK_DET_LIN_9 : ulbrs_pkg::BRK_DET_LIN_8)
                              : ulbrs_pkg::BRK_DET_STD;
    assign brk_lim = 16'(brk_bits * BIT_CLKS);
    assign tx_bits = (long_r ? ulbrs_pkg::BRK_TX_LONG : ulbrs_pkg::BRK_TX_SHORT) + {4'h0, nine_r};
    assign tx_lim = 16'(tx_bits * BIT_CLKS);
    assign last_bit = nine_r ? ulbrs_pkg::LAST_BIT_9 : ulbrs_pkg::LAST_BIT_8;
    assign brk_det = ~rx_c & (low_r == brk_lim - 16'h0001);
    assign brk_evt = brk_det & lin_break_detect_enable_r;
    assign idle_det = rx_c & armed_r & (high_r == char_lim - 16'h0001);
    assign idle_set = idle_det & (~stby_r | widle_r);

    assign aw_take = s_axi_awvalid & awready_r;
    assign w_take = s_axi_wvalid & wready_r;
    assign ar_take = s_axi_arvalid & arready_r;
    assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wr_en = do_write & wstrb_r[0];
    assign wr_sts2 = wr_en & (awaddr_r == ulbrs_pkg::STS2_ADDR);
    assign wr_evt = wr_en & (awaddr_r == ulbrs_pkg::EVT_ADDR);
    assign wr_mask = wr_en & (awaddr_r == ulbrs_pkg::MASK_ADDR);
    assign wr_ctrl = wr_en & (awaddr_r == ulbrs_pkg::CTRL_ADDR);
    assign wr_hit = wr_sts2 | wr_evt | wr_mask | wr_ctrl | (awaddr_r == ulbrs_pkg::DATA_ADDR) | ~wstrb_r[0];

    // event flags
    always_comb begin
        evt_set = 5'h00;
        evt_set[ulbrs_pkg::EVT_BRK] = brk_evt;
        evt_set[ulbrs_pkg::EVT_EDGE] = edge_evt;
        evt_set[ulbrs_pkg::EVT_IDLE] = idle_set;
        evt_set[ulbrs_pkg::EVT_FE] = fe_evt & ~lin_break_detect_enable_r;
        evt_set[ulbrs_pkg::EVT_FULL] = full_evt & ~lin_break_detect_enable_r;
        evt_clr = wr_evt ? wdata_r[4:0] : 5'h00;
        evt_clr[ulbrs_pkg::EVT_BRK] = evt_clr[ulbrs_pkg::EVT_BRK] | (wr_sts2 & wdata_r[ulbrs_pkg::STS2_BRK]);
        evt_clr[ulbrs_pkg::EVT_EDGE] = evt_clr[ulbrs_pkg::EVT_EDGE] | (wr_sts2 & wdata_r[ulbrs_pkg::STS2_EDGE]);
    end

    for (genvar gi = 0; gi < ulbrs_pkg::EVT_N; gi++) begin : g_flag
        ulbrs_sticky u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(evt_set[gi]),
            .clr(evt_clr[gi]),
            .q(evt_q[gi])
        );
    end

    // receiver, break and idle timing
    always_comb begin
        rx_state_nxt = rx_state_r;
        cyc_nxt = cyc_r + 16'h0001;
        nbit_nxt = nbit_r;
        shift_nxt = shift_r;
        rxdata_nxt = rxdata_r;
        raf_nxt = raf_r;
        armed_nxt = armed_r;
        fe_evt = 1'b0;
        full_evt = 1'b0;
        low_nxt = rx_c ? 16'h0000 : ((low_r == 16'hffff) ? low_r : low_r + 16'h0001);
        high_nxt = ~rx_c ? 16'h0000 : ((high_r == 16'hffff) ? high_r : high_r + 16'h0001);
        unique case (rx_state_r)
            ulbrs_pkg::RX_IDLE: begin
                cyc_nxt = 16'h0000;
                if (!rx_c) begin
                    rx_state_nxt = ulbrs_pkg::RX_START;
                    raf_nxt = 1'b1;
                end
            end
            ulbrs_pkg::RX_START: begin
                if (cyc_r == HALF_LIM) begin
                    cyc_nxt = 16'h0000;
                    if (rx_c) begin
                        rx_state_nxt = ulbrs_pkg::RX_IDLE;
                        raf_nxt = 1'b0;
                    end else begin
                        rx_state_nxt = ulbrs_pkg::RX_DATA;
                        nbit_nxt = 4'h0;
                        armed_nxt = 1'b1;
                    end
                end
            end
            ulbrs_pkg::RX_DATA: begin
                if (cyc_r == FULL_LIM) begin
                    cyc_nxt = 16'h0000;
                    shift_nxt = {rx_c, shift_r[8:1]};
                    nbit_nxt = nbit_r + 4'h1;
                    if (nbit_r == last_bit) begin
                        rx_state_nxt = ulbrs_pkg::RX_STOP;
                    end
                end
            end
            ulbrs_pkg::RX_STOP: begin
                if (cyc_r == FULL_LIM) begin
                    cyc_nxt = 16'h0000;
                    full_evt = 1'b1;
                    fe_evt = ~rx_c;
                    if (!lin_break_detect_enable_r) begin
                        rxdata_nxt = nine_r ? shift_r : {1'b0, shift_r[8:1]};
                    end
                    rx_state_nxt = rx_c ? ulbrs_pkg::RX_IDLE : ulbrs_pkg::RX_WAIT;
                end
            end
            ulbrs_pkg::RX_WAIT: begin
                cyc_nxt = 16'h0000;
                if (rx_c) begin
                    rx_state_nxt = ulbrs_pkg::RX_IDLE;
                end
            end
            default: begin
                rx_state_nxt = ulbrs_pkg::RX_IDLE;
            end
        endcase
        if (idle_det) begin
            armed_nxt = 1'b0;
            raf_nxt = 1'b0;
        end
    end

    // configuration, break transmitter and interrupt
    always_comb begin
        inv_nxt = wr_sts2 ? wdata_r[ulbrs_pkg::STS2_INV] : inv_r;
        widle_nxt = wr_sts2 ? wdata_r[ulbrs_pkg::STS2_WIDLE] : widle_r;
        long_nxt = wr_sts2 ? wdata_r[ulbrs_pkg::STS2_LONG] : long_r;
        lin_break_detect_enable_nxt = wr_sts2 ? wdata_r[ulbrs_pkg::STS2_LIN_BREAK_DETECT_ENABLE] : lin_break_detect_enable_r;
        nine_nxt = wr_ctrl ? wdata_r[ulbrs_pkg::CTRL_NINE] : nine_r;
        stby_nxt = wr_ctrl ? wdata_r[ulbrs_pkg::CTRL_STBY] : stby_r;
        mask_nxt = wr_mask ? wdata_r[4:0] : mask_r;
        tx_act_nxt = tx_act_r;
        tx_cyc_nxt = tx_cyc_r;
        txd_nxt = txd_r;
        if (!tx_act_r) begin
            if (wr_ctrl && wdata_r[ulbrs_pkg::CTRL_SBK]) begin
                tx_act_nxt = 1'b1;
                tx_cyc_nxt = 16'h0000;
                txd_nxt = 1'b0;
            end
        end else if (tx_cyc_r == tx_lim - 16'h0001) begin
            tx_act_nxt = 1'b0;
            txd_nxt = 1'b1;
        end else begin
            tx_cyc_nxt = tx_cyc_r + 16'h0001;
        end
        irq_nxt = |(evt_q & mask_r);
    end

    // axi4-lite slave
    always_comb begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (s_axi_araddr)
            ulbrs_pkg::STS2_ADDR: rd_data = {24'h000000, evt_q[ulbrs_pkg::EVT_BRK], evt_q[ulbrs_pkg::EVT_EDGE],
                                             1'b0, inv_r, widle_r, long_r, lin_break_detect_enable_r, raf_r};
            ulbrs_pkg::EVT_ADDR: rd_data = {27'h0000000, evt_q};
            ulbrs_pkg::MASK_ADDR: rd_data = {27'h0000000, mask_r};
            ulbrs_pkg::CTRL_ADDR: rd_data = {29'h00000000, tx_act_r, stby_r, nine_r};
            ulbrs_pkg::DATA_ADDR: rd_data = {23'h000000, rxdata_r};
            default: rd_ok = 1'b0;
        endcase
        aw_hold_nxt = (aw_hold_r & ~do_write) | aw_take;
        w_hold_nxt = (w_hold_r & ~do_write) | w_take;
        awaddr_nxt = aw_take ? s_axi_awaddr : awaddr_r;
        wdata_nxt = w_take ? s_axi_wdata : wdata_r;
        wstrb_nxt = w_take ? s_axi_wstrb : wstrb_r;
        awready_nxt = ~aw_hold_nxt;
        wready_nxt = ~w_hold_nxt;
        bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
        bresp_nxt = do_write ? (wr_hit ? ulbrs_pkg::RESP_OKAY : ulbrs_pkg::RESP_SLVERR) : bresp_r;
        rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
        arready_nxt = ~rvalid_nxt;
        rdata_nxt = ar_take ? rd_data : rdata_r;
        rresp_nxt = ar_take ? (rd_ok ? ulbrs_pkg::RESP_OKAY : ulbrs_pkg::RESP_SLVERR) : rresp_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_r <= ulbrs_pkg::RX_IDLE;
            {cyc_r, low_r, high_r, tx_cyc_r} <= 64'h0;
            nbit_r <= 4'h0;
            shift_r <= 9'h000;
            rxdata_r <= 9'h000;
            {raf_r, armed_r} <= 2'h0;
            rx_prev_r <= 1'b1;
            {inv_r, widle_r, long_r, lin_break_detect_enable_r} <= ulbrs_pkg::STS2_CFG_RST;
            {nine_r, stby_r} <= ulbrs_pkg::CTRL_RST;
            mask_r <= ulbrs_pkg::MASK_RST;
            tx_act_r <= 1'b0;
            txd_r <= 1'b1;
            irq_r <= 1'b0;
            {aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r} <= 7'h00;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            rdata_r <= 32'h0;
            {bresp_r, rresp_r} <= 4'h0;
        end else begin
            rx_state_r <= rx_state_nxt;
            {cyc_r, low_r, high_r, tx_cyc_r} <= {cyc_nxt, low_nxt, high_nxt, tx_cyc_nxt};
            nbit_r <= nbit_nxt;
            shift_r <= shift_nxt;
            rxdata_r <= rxdata_nxt;
            {raf_r, armed_r} <= {raf_nxt, armed_nxt};
            rx_prev_r <= rxd;
            {inv_r, widle_r, long_r, lin_break_detect_enable_r} <= {inv_nxt, widle_nxt, long_nxt, lin_break_detect_enable_nxt};
            {nine_r, stby_r} <= {nine_nxt, stby_nxt};
            mask_r <= mask_nxt;
            tx_act_r <= tx_act_nxt;
            txd_r <= txd_nxt;
            irq_r <= irq_nxt;
            {aw_hold_r, w_hold_r, awready_r, wready_r} <= {aw_hold_nxt, w_hold_nxt, awready_nxt, wready_nxt};
            {bvalid_r, arready_r, rvalid_r} <= {bvalid_nxt, arready_nxt, rvalid_nxt};
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            rdata_r <= rdata_nxt;
            {bresp_r, rresp_r} <= {bresp_nxt, rresp_nxt};
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign txd = txd_r;
    assign irq = irq_r;

    // checks
    logic [15:0] chk_txlow_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_txlow_r <= 16'h0000;
        end else begin
            chk_txlow_r <= txd_r ? 16'h0000 : chk_txlow_r + 16'h0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start_seen;
        rx_state_r == ulbrs_pkg::RX_IDLE && rxd == inv_r;
    endsequence
    sequence s_stop_low;
        rx_state_r == ulbrs_pkg::RX_STOP && cyc_r == FULL_LIM && rxd == inv_r && !lin_break_detect_enable_r;
    endsequence

    AST_BRK_SET: assert property (lin_break_detect_enable_r && brk_det |=> evt_q[ulbrs_pkg::EVT_BRK])
        else $error("break not flagged");
    AST_BRK_CLR: assert property (wr_sts2 && wdata_r[7] && !brk_evt |=> !evt_q[ulbrs_pkg::EVT_BRK])
        else $error("break flag not cleared by one");
    AST_EDGE_SET: assert property (((!inv_r && $fell(rxd)) || (inv_r && $rose(rxd))) && $stable(inv_r)
                                   |=> evt_q[ulbrs_pkg::EVT_EDGE])
        else $error("active edge not flagged");
    AST_EDGE_HOLD: assert property (evt_q[ulbrs_pkg::EVT_EDGE] && !(wr_sts2 && wdata_r[6])
                                    && !(wr_evt && wdata_r[1]) |=> evt_q[ulbrs_pkg::EVT_EDGE])
        else $error("edge flag lost");
    AST_INV_START: assert property (s_start_seen |=> rx_state_r == ulbrs_pkg::RX_START && raf_r)
        else $error("start not seen through inversion");
    AST_WAKE_IDLE: assert property (idle_det && stby_r && !widle_r && !evt_q[ulbrs_pkg::EVT_IDLE]
                                    |=> !evt_q[ulbrs_pkg::EVT_IDLE])
        else $error("idle flagged in standby");
    AST_TX_BRK_LEN: assert property ($rose(txd_r) |-> chk_txlow_r == $past(tx_lim))
        else $error("wrong sent break length");
    AST_LIN_GATE: assert property (lin_break_detect_enable_r |-> !evt_set[ulbrs_pkg::EVT_FE] && !evt_set[ulbrs_pkg::EVT_FULL])
        else $error("flag set while lin detection on");
    AST_BRK_LIN_THR: assert property (brk_evt |-> low_r + 16'h0001 == (nine_r ? 16'(12 * BIT_CLKS)
                                                                           : 16'(11 * BIT_CLKS)))
        else $error("lin break threshold wrong");
    AST_BRK_STD_THR: assert property (!lin_break_detect_enable_r && !rx_c && low_r + 16'h0001 == 16'(10 * BIT_CLKS)
                                      |-> brk_det)
        else $error("standard break threshold wrong");
    AST_RAF_IDLE: assert property (idle_det |=> !raf_r ##1 !raf_r || rx_state_r != ulbrs_pkg::RX_IDLE)
        else $error("active flag not cleared at idle");
    AST_FE: assert property (s_stop_low |=> evt_q[ulbrs_pkg::EVT_FE] && evt_q[ulbrs_pkg::EVT_FULL])
        else $error("framing error not flagged");
    AST_RSV: assert property (ar_take && s_axi_araddr == ulbrs_pkg::STS2_ADDR |=> rvalid_r && !rdata_r[5])
        else $error("reserved bit reads one");
endmodule : ulbrs_top

// ### ulbrs_node.sv
// serial bus node model: drives the receive line, times the sent break
`timescale 1ns/1ps
module ulbrs_node #(
    parameter int BIT_CLKS = 4
) (
    // clock
    input wire logic aclk,
    // line
    output logic rxd,
    input wire logic txd,
    // last low time of txd in cycles
    output logic [15:0] low_run
);
    logic lvl = 1'b1;
    logic inv = 1'b0;
    logic [15:0] cnt = 16'h0000;
    // released line rests high, or low while inv is set
    assign rxd = lvl ^ inv;
    task put(input logic b, input int n);
        lvl <= b;
        repeat (n) @(posedge aclk);
    endtask : put
    task send(input logic [8:0] d, input int nb, input logic stop);
        put(1'b0, BIT_CLKS);
        for (int i = 0; i < nb; i++) put(d[i], BIT_CLKS);
        put(stop, BIT_CLKS);
        put(1'b1, 12 * BIT_CLKS);
    endtask : send
    task brk(input int n);
        put(1'b0, n * BIT_CLKS);
        put(1'b1, 12 * BIT_CLKS);
    endtask : brk
    always @(posedge aclk) begin
        cnt <= txd ? 16'h0000 : cnt + 16'h0001;
        if (txd && cnt != 16'h0000) low_run <= cnt;
    end
endmodule : ulbrs_node

// ### testbench.sv
// self-checking bench for the lin break and receive status block
`timescale 1ns/1ps
module testbench;
    localparam int B = 4;
    localparam logic [7:0] S2 = ulbrs_pkg::STS2_ADDR;
    localparam logic [7:0] EV = ulbrs_pkg::EVT_ADDR;
    localparam logic [7:0] MK = ulbrs_pkg::MASK_ADDR;
    localparam logic [7:0] CT = ulbrs_pkg::CTRL_ADDR;
    localparam logic [7:0] DA = ulbrs_pkg::DATA_ADDR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
    logic [1:0] bresp, rresp, resp_v;
    logic [31:0] rdata, rd_v;
    logic [15:0] low_run;
    int mismatches = 0;
    int num_checks = 0;
    always #10 aclk = ~aclk;
    ulbrs_top #(.BIT_CLKS(B)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rxd(rxd), .txd(txd), .irq(irq));
    ulbrs_node #(.BIT_CLKS(B)) node (.aclk(aclk), .rxd(rxd), .txd(txd), .low_run(low_run));
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // bready stays high afterwards, so a call right after this one never drives it twice in one step
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp_v = bresp;
    endtask : wr
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // rready stays high afterwards for the same reason
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_v = rdata;
        resp_v = rresp;
    endtask : rd
    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm, input logic [31:0] m = 32'hffffffff);
        rd(a);
        cmp(nm, e, rd_v & m);
    endtask : rchk
    task chk_irq(input logic e);
        cyc(2);
        #1;
        cmp("irq", e, irq);
        @(posedge aclk);
    endtask : chk_irq
    task tend(input string s);
        $display("test %s done", s);
    endtask : tend
    initial begin
        cyc(10);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(S2, 0, "sts2");
        rchk(EV, 0, "evt");
        rchk(MK, 0, "mask");
        rchk(CT, 0, "ctrl");
        rd(8'hfc);
        cmp("rresp", ulbrs_pkg::RESP_SLVERR, resp_v);
        wr(8'hfc, 32'hff);
        cmp("bresp", ulbrs_pkg::RESP_SLVERR, resp_v);
        wstrb <= 4'h0;
        wr(MK, 32'h1f);
        wstrb <= 4'h1;
        rchk(MK, 0, "mask");
        wr(S2, 32'h2f);
        rchk(S2, 32'h0e, "sts2");
        wr(S2, 0);
        tend("regs");
        fork
            node.send(9'h055, 8, 1'b1);
            begin
                cyc(4 * B);
                rchk(S2, 32'h41, "sts2");
            end
        join
        rchk(S2, 32'h40, "sts2");
        rchk(EV, 32'h16, "evt");
        rchk(DA, 32'h055, "data");
        wr(S2, 0);
        rchk(S2, 32'h40, "sts2");
        wr(S2, 32'h40);
        rchk(S2, 0, "sts2");
        wr(EV, 32'h1f);
        tend("frame");
        wr(S2, 32'h04);
        node.send(9'h00f, 8, 1'b0);
        rchk(EV, 32'h1e, "evt");
        wr(S2, 0);
        node.brk(12);
        rchk(S2, 0, "brk", 32'h80);
        wr(EV, 32'h1f);
        tend("framing");
        wr(S2, 32'h02);
        node.send(9'h000, 8, 1'b0);
        rchk(EV, 32'h06, "evt");
        wr(MK, 32'h01);
        for (int n = 0; n < 2; n++) begin
            wr(CT, n);
            wr(EV, 32'h1f);
            node.brk(10 + n);
            rchk(S2, 0, "brk", 32'h80);
            node.brk(11 + n);
            rchk(S2, 32'h80, "brk", 32'h80);
            chk_irq(1'b1);
            wr(S2, 32'h02);
            rchk(S2, 32'h80, "brk", 32'h80);
            wr(S2, 32'h82);
            rchk(S2, 0, "brk", 32'h80);
            chk_irq(1'b0);
        end
        wr(MK, 0);
        tend("lin");
        for (int w = 0; w < 2; w++) begin
            wr(CT, 32'h02);
            wr(S2, w * 8);
            wr(EV, 32'h1f);
            node.send(9'h033, 8, 1'b1);
            rchk(EV, w * 4, "idle", 32'h04);
        end
        tend("standby");
        for (int k = 0; k < 4; k++) begin
            wr(S2, (k % 2) * 4);
            wr(CT, 32'h04 + k / 2);
            cyc(15 * B + 8);
            cmp("txd low", (10 + 3 * (k % 2) + k / 2) * B, low_run);
        end
        wr(CT, 0);
        tend("break");
        wr(S2, 32'h10);
        node.inv <= 1'b1;
        cyc(25 * B);
        wr(EV, 32'h1f);
        node.send(9'h0a5, 8, 1'b1);
        rchk(EV, 32'h16, "evt");
        rchk(DA, 32'h0a5, "data");
        tend("invert");
        test_done;
    end
    initial begin
        cyc(20000);
        mismatches++;
        test_done;
    end
endmodule : testbench
